// ===== include/cpsel_defs.svh
// Constants for the control port pin function selector.
// Assumes inclusion by bare name from design files only.
`ifndef CPSEL_DEFS_SVH
`define CPSEL_DEFS_SVH
`define CPSEL_IF_MUX 2'h0
`define CPSEL_IF_NONMUX 2'h1
`define CPSEL_IF_SERIAL 2'h2
`define CPSEL_IF_HW 2'h3
`define CPSEL_MODE_W 4
`define CPSEL_ADDR_W 8
`define CPSEL_MODE_T1 4'h0
`define CPSEL_MODE_E1 4'h1
`define CPSEL_MODE_BIT2 2
`define CPSEL_MODE_BIT3 3
`endif

// ===== include/cpsel_pkg.sv
// Types for the control port pin function selector.
// Assumes no other package.
package cpsel_pkg;
	typedef enum logic [1:0] {CPSEL_MUX, CPSEL_NONMUX, CPSEL_SERIAL, CPSEL_HW} cpsel_ifmode_t;
	typedef enum logic [1:0] {CPSEL_IDLE, CPSEL_RD, CPSEL_WR} cpsel_acc_t;
endpackage

// ===== core/cpsel_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cpsel_sync #(
	parameter int W = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cpsel_sync_st_t;
	cpsel_sync_st_t st_r;
	cpsel_sync_st_t st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = i_d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign o_q = st_r.s2;
endmodule
`default_nettype wire

// ===== core/cpsel_top.sv
// Control port pin decoder: turns the multifunction strobe pins into bus accesses or hardware straps.
// Assumes pins are asynchronous to i_core_clk; the mode straps stay static during operation.
`timescale 1ns/10ps
`default_nettype none
`include "cpsel_defs.svh"
module cpsel_top (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [1:0] i_interface_select,
	input wire logic i_bus_style_strap,
	input wire logic i_data_strobe,
	input wire logic i_cs_n,
	input wire logic i_address_strobe_pin,
	input wire logic i_wr_pin,
	input wire logic [7:0] i_ad,
	input wire logic [6:0] i_addr_low,
	input wire logic [3:0] i_tx_mode_core,
	input wire logic [3:0] i_rx_mode_core,
	output logic [1:0] o_if_mode,
	output logic o_rd_pulse,
	output logic o_wr_pulse,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_rx_mode_sel_bit2,
	output logic o_tx_mode_sel_bit3,
	output logic o_clk_prescale_sel_bit1,
	output logic o_line_code_enable,
	output logic o_remote_loopback
);
	localparam int NS = 22;
	logic rst_a_r;
	logic rst_b_r;
	logic [NS-1:0] pins_s;
	typedef struct packed
	{
		cpsel_pkg::cpsel_acc_t acc;
		logic as_d;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic rd_p;
		logic wr_p;
		logic [1:0] ifm;
		logic rxb2;
		logic txb3;
		logic clk_prescale_sel_bit1;
		logic line_code_enable_strap;
		logic remote_loopback_strap;
	} cpsel_st_t;
	cpsel_st_t st_r;
	cpsel_st_t st_nxt;
	logic [1:0] bis;
	logic bus_style_strap;
	logic ds;
	logic cs_n;
	logic cs_act;
	logic as_p;
	logic wr;
	logic [7:0] ad;
	logic [6:0] alo;
	logic rd_act;
	logic wr_act;
	logic hw_coded;
	always_ff @(posedge i_core_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_a_r <= 1'b0;
			rst_b_r <= 1'b0;
		end
		else
		begin
			rst_a_r <= 1'b1;
			rst_b_r <= rst_a_r;
		end
	end
	cpsel_sync #(.W(NS)) u_sync (
		.i_core_clk(i_core_clk),
		.i_rst_n(rst_b_r),
		.i_d({i_interface_select, i_bus_style_strap, i_data_strobe, ~i_cs_n, i_address_strobe_pin, i_wr_pin,
			i_ad, i_addr_low}),
		.o_q(pins_s)
	);
	assign {bis, bus_style_strap, ds, cs_act, as_p, wr, ad, alo} = pins_s;
	// Chip select crosses in its active-high sense, so the synchroniser's reset value reads as deselected.
	assign cs_n = !cs_act;
	// Strobe decode; in data-strobe timing the write pin carries direction (high = read).
	always_comb
	begin
		rd_act = 1'b0;
		wr_act = 1'b0;
		if (bus_style_strap)
		begin
			if ((bis == `CPSEL_IF_NONMUX) ? ds : !ds)
			begin
				rd_act = wr;
				wr_act = !wr;
			end
		end
		else
		begin
			rd_act = !ds;
			wr_act = !wr;
		end
		if (cs_n || bis[1])
		begin
			rd_act = 1'b0;
			wr_act = 1'b0;
		end
	end
	assign hw_coded = (i_rx_mode_core == `CPSEL_MODE_T1) || (i_rx_mode_core == `CPSEL_MODE_E1);
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rd_p = 1'b0;
		st_nxt.wr_p = 1'b0;
		st_nxt.as_d = as_p;
		st_nxt.ifm = bis;
		if (bis == `CPSEL_IF_MUX && as_p && !st_r.as_d)
			st_nxt.addr = ad;
		else if (bis == `CPSEL_IF_NONMUX)
			st_nxt.addr = {as_p, alo};
		case (st_r.acc)
			cpsel_pkg::CPSEL_IDLE:
			begin
				if (rd_act)
				begin
					st_nxt.acc = cpsel_pkg::CPSEL_RD;
					st_nxt.rd_p = 1'b1;
				end
				else if (wr_act)
					st_nxt.acc = cpsel_pkg::CPSEL_WR;
			end
			cpsel_pkg::CPSEL_RD:
			begin
				if (!rd_act)
					st_nxt.acc = cpsel_pkg::CPSEL_IDLE;
			end
			cpsel_pkg::CPSEL_WR:
			begin
				st_nxt.wdata = ad;
				if (!wr_act)
				begin
					st_nxt.acc = cpsel_pkg::CPSEL_IDLE;
					st_nxt.wr_p = 1'b1;
				end
			end
			default:
				st_nxt.acc = cpsel_pkg::CPSEL_IDLE;
		endcase
		if (bis == `CPSEL_IF_HW)
		begin
			st_nxt.acc = cpsel_pkg::CPSEL_IDLE;
			st_nxt.rd_p = 1'b0;
			st_nxt.wr_p = 1'b0;
			st_nxt.rxb2 = ds;
			st_nxt.txb3 = wr;
			st_nxt.clk_prescale_sel_bit1 = as_p;
			st_nxt.line_code_enable_strap = bus_style_strap && hw_coded;
			st_nxt.remote_loopback_strap = cs_n && (i_tx_mode_core == i_rx_mode_core);
		end
		else
		begin
			st_nxt.rxb2 = 1'b0;
			st_nxt.txb3 = 1'b0;
			st_nxt.clk_prescale_sel_bit1 = 1'b0;
			st_nxt.line_code_enable_strap = 1'b0;
			st_nxt.remote_loopback_strap = 1'b0;
		end
	end
	always_ff @(posedge i_core_clk or negedge rst_b_r)
	begin
		if (!rst_b_r)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign o_if_mode = st_r.ifm;
	assign o_rd_pulse = st_r.rd_p;
	assign o_wr_pulse = st_r.wr_p;
	assign o_addr = st_r.addr;
	assign o_wdata = st_r.wdata;
	assign o_rx_mode_sel_bit2 = st_r.rxb2;
	assign o_tx_mode_sel_bit3 = st_r.txb3;
	assign o_clk_prescale_sel_bit1 = st_r.clk_prescale_sel_bit1;
	assign o_line_code_enable = st_r.line_code_enable_strap;
	assign o_remote_loopback = st_r.remote_loopback_strap;

	chk_cs_blocks: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		$past(cs_n) && $past(bis) != `CPSEL_IF_HW && $past(st_r.acc) == cpsel_pkg::CPSEL_IDLE |-> !o_rd_pulse)
		else $error("read pulse with chip select high");
	chk_ale_capture: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_MUX && $rose(as_p) && $stable(bis) |=> o_addr == $past(ad))
		else $error("address not latched on strobe edge");
	chk_a7_map: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_NONMUX |=> o_addr[7] == $past(as_p))
		else $error("address bit 7 wrong");
	chk_hw_prescale: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_HW |=> o_clk_prescale_sel_bit1 == $past(as_p))
		else $error("prescale bit wrong");
	chk_hw_rxbit: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_HW |=> o_rx_mode_sel_bit2 == $past(ds))
		else $error("rx mode bit wrong");
	chk_hw_txbit: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_HW |=> o_tx_mode_sel_bit3 == $past(wr))
		else $error("tx mode bit wrong");
	chk_line_code: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		o_line_code_enable |-> o_if_mode == `CPSEL_IF_HW)
		else $error("line code outside hardware mode");
	chk_line_valid: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_HW |=> o_line_code_enable == ($past(bus_style_strap) &&
		($past(i_rx_mode_core) == `CPSEL_MODE_T1 || $past(i_rx_mode_core) == `CPSEL_MODE_E1)))
		else $error("line code enable wrong in hardware mode");
	chk_loopback: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		bis == `CPSEL_IF_HW && cs_n && i_tx_mode_core != i_rx_mode_core |=> !o_remote_loopback)
		else $error("loopback with mismatched modes");
	chk_no_hw_access: assert property (@(posedge i_core_clk) disable iff (!rst_b_r)
		o_if_mode == `CPSEL_IF_HW |-> !o_wr_pulse && !o_rd_pulse)
		else $error("access in hardware mode");
	cov_read: cover property (@(posedge i_core_clk) disable iff (!rst_b_r) o_rd_pulse);
	cov_write: cover property (@(posedge i_core_clk) disable iff (!rst_b_r) o_wr_pulse);
	cov_loop: cover property (@(posedge i_core_clk) disable iff (!rst_b_r) o_remote_loopback);
endmodule
`default_nettype wire

// ===== test/cpsel_host.sv
// Host model that drives the strobe, chip select and address/data pins of the pin selector.
// Assumes the bench calls its tasks one at a time and keeps the mode straps static meanwhile.
`timescale 1ns/10ps
`default_nettype none
module cpsel_host (
	input wire logic i_core_clk,
	input wire logic [1:0] i_if,
	input wire logic i_bts,
	output logic o_data_strobe,
	output logic o_cs_n,
	output logic o_as,
	output logic o_wr,
	output logic [7:0] o_ad,
	output logic [6:0] o_addr_low
);
	logic act;
	assign act = (i_if == 2'h1) & i_bts;
	task automatic set_pins(input logic cs_n, input logic ds, input logic as, input logic wr);
	begin
		o_cs_n = cs_n;
		o_data_strobe = ds;
		o_as = as;
		o_wr = wr;
	end
	endtask
	// The released bus shows the inverse of its last value so stale data cannot match.
	task automatic access(input logic rd, input logic cs_n, input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge i_core_clk);
		set_pins(cs_n, ~act, a[7] & (i_if != 2'h0), rd | ~i_bts);
		o_ad = a;
		o_addr_low = a[6:0];
		if (i_if == 2'h0)
		begin
			repeat (2) @(negedge i_core_clk);
			o_as = 1'b1;
			repeat (2) @(negedge i_core_clk);
			o_as = 1'b0;
		end
		o_ad = rd ? ~a : d;
		repeat (2) @(negedge i_core_clk);
		if (i_bts | rd)
			o_data_strobe = act;
		else
			o_wr = 1'b0;
		repeat (3) @(negedge i_core_clk);
		o_data_strobe = ~act;
		o_wr = rd | ~i_bts;
		repeat (5) @(negedge i_core_clk);
		set_pins(1'b1, ~act, o_as, 1'b1);
		o_ad = ~o_ad;
	end
	endtask
	initial
	begin
		set_pins(1'b1, 1'b1, 1'b0, 1'b1);
		o_ad = 8'h00;
		o_addr_low = 7'h00;
	end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the control port pin selector.
// Assumes the host model drives all strobe pins; the bench drives straps and core modes.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst_n = 1'b0, bus_style_strap = 1'b0;
	logic [1:0] if_sel = 2'h0;
	logic [3:0] txm = 4'h0, rxm = 4'h0;
	logic ds, cs_n, as, wr;
	logic rcs, rds, ras, rwr;
	logic [7:0] ad;
	logic [6:0] alow;
	logic [1:0] o_if_mode;
	logic o_rd_pulse, o_wr_pulse, o_rx2, o_tx3, o_ps1, o_lce, o_rlb;
	logic [7:0] o_addr, o_wdata;
	int fails = 0, checked = 0, cyc = 0, rd_cnt = 0, wr_cnt = 0;
	// Rows: interface select, cs, ds, as, wr, strap, tx mode, rx mode, then rx2 tx3 ps1 lce rlb.
	logic [19:0] rows [6] = '{20'he0001, 20'hf0030, 20'hce22e, 20'he2aa1, 20'hd2012, 20'h7e000};
	cpsel_host host (.i_core_clk(clk), .i_if(if_sel), .i_bts(bus_style_strap), .o_data_strobe(ds), .o_cs_n(cs_n),
		.o_as(as), .o_wr(wr), .o_ad(ad), .o_addr_low(alow));
	cpsel_top dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_interface_select(if_sel), .i_bus_style_strap(bus_style_strap),
		.i_data_strobe(ds), .i_cs_n(cs_n), .i_address_strobe_pin(as), .i_wr_pin(wr), .i_ad(ad),
		.i_addr_low(alow), .i_tx_mode_core(txm), .i_rx_mode_core(rxm), .o_if_mode(o_if_mode),
		.o_rd_pulse(o_rd_pulse), .o_wr_pulse(o_wr_pulse), .o_addr(o_addr), .o_wdata(o_wdata),
		.o_rx_mode_sel_bit2(o_rx2), .o_tx_mode_sel_bit3(o_tx3), .o_clk_prescale_sel_bit1(o_ps1),
		.o_line_code_enable(o_lce), .o_remote_loopback(o_rlb));
	initial
		forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		rd_cnt <= rd_cnt + (o_rd_pulse === 1'b1);
		wr_cnt <= wr_cnt + (o_wr_pulse === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 4000)
		begin
			fails++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
	begin
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task automatic set_mode(input logic [1:0] ifs, input logic b);
	begin
		if_sel = ifs;
		bus_style_strap = b;
		host.set_pins(1'b1, ~((ifs == 2'h1) & b), 1'b0, 1'b1);
		repeat (6) @(negedge clk);
	end
	endtask
	task automatic run_acc(input logic rd, input logic c, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] erd, input logic [7:0] ewr, input logic [7:0] ea);
	begin
		@(negedge clk);
		rd_cnt = 0;
		wr_cnt = 0;
		host.access(rd, c, a, d);
		chk(8'(rd_cnt), erd);
		chk(8'(wr_cnt), ewr);
		chk(o_addr, ea);
		if (ewr == 8'h01)
			chk(o_wdata, d);
	end
	endtask
	task automatic report_and_stop();
	begin
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		chk({1'b0, o_rd_pulse, o_wr_pulse, o_rx2, o_tx3, o_ps1, o_lce, o_rlb}, 8'h00);
		chk(o_addr | o_wdata, 8'h00);
		rst_n = 1'b1;
		$display("Test reset done");
		foreach (rows[i])
		begin
			{if_sel, rcs, rds, ras, rwr, bus_style_strap, txm, rxm} = rows[i][19:5];
			host.set_pins(rcs, rds, ras, rwr);
			repeat (5) @(negedge clk);
			chk({3'h0, o_rx2, o_tx3, o_ps1, o_lce, o_rlb}, {3'h0, rows[i][4:0]});
			chk({6'h00, o_if_mode}, {6'h00, rows[i][19:18]});
		end
		$display("Test strap table done");
		txm = 4'h0;
		rxm = 4'h0;
		set_mode(2'h0, 1'b0);
		run_acc(1'b0, 1'b0, 8'h5a, 8'ha5, 8'h00, 8'h01, 8'h5a);
		run_acc(1'b1, 1'b0, 8'hc3, 8'h00, 8'h01, 8'h00, 8'hc3);
		run_acc(1'b0, 1'b1, 8'h3c, 8'h99, 8'h00, 8'h00, 8'h3c);
		$display("Test multiplexed done");
		set_mode(2'h1, 1'b1);
		run_acc(1'b0, 1'b0, 8'h81, 8'h3c, 8'h00, 8'h01, 8'h81);
		run_acc(1'b1, 1'b0, 8'h7e, 8'h00, 8'h01, 8'h00, 8'h7e);
		set_mode(2'h1, 1'b0);
		run_acc(1'b1, 1'b0, 8'he5, 8'h00, 8'h01, 8'h00, 8'he5);
		$display("Test nonmultiplexed done");
		set_mode(2'h0, 1'b1);
		run_acc(1'b0, 1'b0, 8'h96, 8'h69, 8'h00, 8'h01, 8'h96);
		$display("Test multiplexed data strobe done");
		set_mode(2'h2, 1'b0);
		run_acc(1'b0, 1'b0, 8'h11, 8'h22, 8'h00, 8'h00, 8'h96);
		$display("Test serial done");
		rd_cnt = 0;
		wr_cnt = 0;
		rst_n = 1'b0;
		@(negedge clk);
		chk({1'b0, o_rd_pulse, o_wr_pulse, o_rx2, o_tx3, o_ps1, o_lce, o_rlb}, 8'h00);
		chk(o_addr | o_wdata, 8'h00);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		chk(8'(rd_cnt), 8'h00);
		chk(8'(wr_cnt), 8'h00);
		chk({6'h00, o_if_mode}, 8'h02);
		$display("Test mid reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
